// ==== rtl/dpw_pkg.sv ====
// Shared constants for the dual PWM drive block with fault gating
package dpw_pkg;

  // System clock
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 40;

  // Overcurrent qualification window: strictly longer than this trips
  localparam int unsigned OC_QUAL_NS      = 1000;
  localparam int unsigned OC_QUAL_CYC     = (OC_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Default oscillator timing, counted in system clock cycles
  localparam int unsigned OSC_PERIOD_DEF  = 250;
  localparam int unsigned DEAD_DEF        = 8;
  localparam int unsigned MIN_PULSE_DEF   = 20;

  // Widths
  localparam int unsigned TW              = 16;

  // Channel count
  localparam int unsigned NUM_CH          = 2;

  // Reset values
  localparam logic        DRIVE_RST       = 1'b0;

endpackage

// ==== rtl/dpw_osc.sv ====
// Common oscillator: period counter, period start pulse and charge pump clock
`timescale 1ns/1ns
module dpw_osc
  import dpw_pkg::*;
#(
  parameter int unsigned W = TW
)
(
  // Clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_srst,
  // Timing
  input  wire logic [W-1:0] i_period,
  // Status
  output logic      [W-1:0] o_phase,
  output logic              o_period_start,
  output logic              o_pump_clk
);

  logic [W-1:0] cnt_q;
  logic         pump_q;
  logic         wrap;

  initial
  begin
    if (W < 4) $error("dpw_osc: width too small");
  end

  // A period below two cycles cannot host a pulse; hold the counter at zero
  assign wrap = (cnt_q >= i_period - W'(1)) || (i_period < W'(2));

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      cnt_q <= '0;
    else if (wrap)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + W'(1);
  end

  // Pump toggles twice per period so it runs at the oscillator rate
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      pump_q <= 1'b0;
    else if (wrap || (cnt_q == (i_period >> 1)))
      pump_q <= ~pump_q;
  end

  assign o_phase        = cnt_q;
  assign o_period_start = (cnt_q == '0);
  assign o_pump_clk     = pump_q;

endmodule

// ==== rtl/dpw_chan.sv ====
// One PWM channel: complementary pair, dead time, minimum duty clamp
`timescale 1ns/1ns
module dpw_chan
  import dpw_pkg::*;
#(
  parameter int unsigned W = TW
)
(
  // Clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_srst,
  // Oscillator
  input  wire logic [W-1:0] i_phase,
  input  wire logic [W-1:0] i_period,
  input  wire logic [W-1:0] i_dead,
  input  wire logic [W-1:0] i_min_pulse,
  // Decision and gating
  input  wire logic         i_cmp_high,
  input  wire logic         i_kill,
  // Drive
  output logic              o_drive_hi,
  output logic              o_drive_lo
);

  logic         raw;
  logic         raw_q;
  logic [W-1:0] dt_q;
  logic         hi_q;
  logic         lo_q;
  logic         force_on;
  logic         force_off;
  logic         hi_d;
  logic         lo_d;

  // Each side must pulse every period: high leg at period start,
  // low leg at period end, so neither can stay stuck
  assign force_on  = (i_phase < i_min_pulse);
  assign force_off = (i_phase >= i_period - i_min_pulse);
  assign raw       = force_on ? 1'b1 : (force_off ? 1'b0 : i_cmp_high);

  // Dead-time counter restarts on every edge of the raw decision
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || i_kill)
    begin
      raw_q <= 1'b0;
      dt_q  <= i_dead;
    end
    else if (raw != raw_q)
    begin
      raw_q <= raw;
      dt_q  <= i_dead;
    end
    else if (dt_q != '0)
      dt_q  <= dt_q - W'(1);
  end

  // Neither leg is on while the dead-time counter runs
  assign hi_d = raw_q && (dt_q == '0) && (raw == raw_q);
  assign lo_d = !raw_q && (dt_q == '0) && (raw == raw_q);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || i_kill)
    begin
      hi_q <= DRIVE_RST;
      lo_q <= DRIVE_RST;
    end
    else
    begin
      hi_q <= hi_d;
      lo_q <= lo_d;
    end
  end

  // Kill also gates combinationally so a fault drops outputs at once
  assign o_drive_hi = hi_q && !i_kill;
  assign o_drive_lo = lo_q && !i_kill;

endmodule

// ==== rtl/dpw_top.sv ====
// Dual synchronous PWM drive with overcurrent, undervoltage and disable gating
// Functional notes
// - Both channels share one oscillator and switch at one frequency.
// - Oscillator timing sets period, dead time and minimum pulse width.
// - Each channel makes a complementary drive pair from its comparator.
// - Configurable dead time keeps both legs of a pair low.
// - Minimum duty clamp makes every output pulse each period.
// - Low disable/status line forces all four drive outputs low.
// - Disable/status line is wired-low; both sides may pull it down.
// - Device pulls line low on overcurrent, excess current or undervoltage.
// - Lower-threshold current held over one microsecond shuts outputs down.
// - Upper-threshold excess current shuts outputs down immediately.
// - Undervoltage holds line low until supply and negative bias are good.
// - Charge pump switches at the oscillator frequency.
`timescale 1ns/1ns
module dpw_top
  import dpw_pkg::*;
#(
  parameter int unsigned W           = TW,
  parameter int unsigned OC_CYC      = OC_QUAL_CYC
)
(
  // Clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_srst,
  // Oscillator timing
  input  wire logic [W-1:0]      i_osc_period,
  input  wire logic [W-1:0]      i_dead_time,
  input  wire logic [W-1:0]      i_min_pulse,
  // Error comparator decisions, per channel
  input  wire logic [NUM_CH-1:0] i_err_cmp,
  // Current sense comparators, per channel
  input  wire logic [NUM_CH-1:0] i_oc_low,
  input  wire logic [NUM_CH-1:0] i_oc_high,
  // Supply monitors
  input  wire logic              i_vdd_ok,
  input  wire logic              i_negative_bias_ok,
  // Shared disable/status line (wired-low)
  input  wire logic              i_disable_status_line,
  output logic                   o_disable_status_line,
  output logic                   o_disable_status_line_oe,
  // Bridge gate drive
  output logic [NUM_CH-1:0]      o_bridge_gate_drive_hi,
  output logic [NUM_CH-1:0]      o_bridge_gate_drive_lo,
  // Charge pump
  output logic                   o_charge_pump_capacitor,
  // Status
  output logic                   o_oc_fault,
  output logic                   o_xc_fault,
  output logic                   o_uv_fault
);

  //////////////////////////////////////////////////////////////////////////////

  localparam int unsigned CW = $clog2(OC_CYC + 2);

  logic [W-1:0]          phase;
  logic [CW-1:0]         oc_cnt_q [NUM_CH];
  logic [NUM_CH-1:0]     oc_trip;
  logic                  oc_fault_q;
  logic                  xc_now;
  logic                  uv_now;
  logic                  int_fault;
  logic                  kill;

  initial
  begin
    if (OC_CYC < 1) $error("dpw_top: overcurrent count must be at least one");
    if (W < 4) $error("dpw_top: timing width too small");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Common oscillator feeds both channels

  dpw_osc #(
    .W (W)
  ) u_osc (
    .i_ref_clk      (i_ref_clk),
    .i_srst         (i_srst),
    .i_period       (i_osc_period),
    .o_phase        (phase),
    .o_period_start (),
    .o_pump_clk     (o_charge_pump_capacitor)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Overcurrent qualifier; counter saturates past the window

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_oc
    always_ff @(posedge i_ref_clk)
    begin
      if (i_srst || !i_oc_low[c])
        oc_cnt_q[c] <= '0;
      else if (oc_cnt_q[c] <= CW'(OC_CYC))
        oc_cnt_q[c] <= oc_cnt_q[c] + CW'(1);
    end
    assign oc_trip[c] = (oc_cnt_q[c] > CW'(OC_CYC));
  end

  // Overcurrent latches until reset so the bridge stays off after tripping
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      oc_fault_q <= 1'b0;
    else if (|oc_trip)
      oc_fault_q <= 1'b1;
  end

  // Excess current bypasses any delay
  assign xc_now = |i_oc_high;

  // Lockout holds until both supplies are good
  assign uv_now = !i_vdd_ok || !i_negative_bias_ok;

  assign int_fault = oc_fault_q || (|oc_trip) || xc_now || uv_now;

  //////////////////////////////////////////////////////////////////////////////
  // Wired-low line: drive low only, never high

  assign o_disable_status_line    = 1'b0;
  assign o_disable_status_line_oe = int_fault;

  // External or internal low disables every bridge gate drive output
  assign kill = !i_disable_status_line || int_fault;

  //////////////////////////////////////////////////////////////////////////////
  // Channels

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    dpw_chan #(
      .W (W)
    ) u_chan (
      .i_ref_clk   (i_ref_clk),
      .i_srst      (i_srst),
      .i_phase     (phase),
      .i_period    (i_osc_period),
      .i_dead      (i_dead_time),
      .i_min_pulse (i_min_pulse),
      .i_cmp_high  (i_err_cmp[c]),
      .i_kill      (kill),
      .o_drive_hi  (o_bridge_gate_drive_hi[c]),
      .o_drive_lo  (o_bridge_gate_drive_lo[c])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status

  assign o_oc_fault = oc_fault_q;
  assign o_xc_fault = xc_now;
  assign o_uv_fault = uv_now;

endmodule

// ==== tb/dpw_bridge_model.sv ====
// Bridge gate driver model: counts leg turn-ons and pulls the shared line
`timescale 1ns/1ns
module dpw_bridge_model
(
  // Clock and control
  input  wire logic       i_ref_clk,
  input  wire logic       i_clr,
  input  wire logic       i_fault,
  // Gate drives
  input  wire logic [1:0] i_hi,
  input  wire logic [1:0] i_lo,
  // Observations
  output logic            o_pull_oe,
  output logic [3:0][7:0] o_rises
);
  logic [3:0] legs;
  logic [3:0] prev_q;
  assign legs = {i_lo, i_hi};
  // An over-temperature source only ever pulls low
  assign o_pull_oe = i_fault;
  always_ff @(posedge i_ref_clk)
  begin
    prev_q <= legs;
    for (int k = 0; k < 4; k++)
      o_rises[k] <= i_clr ? 8'h00 : o_rises[k] + {7'h00, legs[k] & !prev_q[k]};
  end
endmodule

// ==== tb/dpw_top_assertions.sv ====
// Port checker for dpw_top
`timescale 1ns/1ns
module dpw_top_chk
  import dpw_pkg::*;
#(
  parameter int unsigned OC_CYC = OC_QUAL_CYC
)
(
  // Watched ports
  input wire logic              i_ref_clk,
  input wire logic              i_srst,
  input wire logic [TW-1:0]     i_dead_time,
  input wire logic [NUM_CH-1:0] i_oc_low,
  input wire logic [NUM_CH-1:0] i_oc_high,
  input wire logic              i_vdd_ok,
  input wire logic              i_negative_bias_ok,
  input wire logic              i_disable_status_line,
  input wire logic              o_disable_status_line,
  input wire logic              o_disable_status_line_oe,
  input wire logic [NUM_CH-1:0] o_bridge_gate_drive_hi,
  input wire logic [NUM_CH-1:0] o_bridge_gate_drive_lo,
  input wire logic              o_oc_fault
);
  // Saturating run length of each lower-threshold comparator
  logic [7:0] c0_q;
  logic [7:0] c1_q;
  logic [7:0] cm;
  logic       drv_on;
  always_ff @(posedge i_ref_clk)
  begin
    c0_q <= (i_srst || !i_oc_low[0]) ? 8'h00 : c0_q + {7'h00, c0_q != 8'hff};
    c1_q <= (i_srst || !i_oc_low[1]) ? 8'h00 : c1_q + {7'h00, c1_q != 8'hff};
  end
  assign cm = (c0_q > c1_q) ? c0_q : c1_q;
  assign drv_on = |{o_bridge_gate_drive_hi, o_bridge_gate_drive_lo};
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  ////////////////////////////////////////////////////////////
  property p_ov;
    (o_bridge_gate_drive_hi & o_bridge_gate_drive_lo) == 2'h0;
  endproperty
  a_ov: assert property (p_ov) else $error("both legs high");
  property p_ln;
    !i_disable_status_line |-> !drv_on;
  endproperty
  a_ln: assert property (p_ln) else $error("drive while line low");
  property p_xc;
    |i_oc_high |-> o_disable_status_line_oe && !drv_on;
  endproperty
  a_xc: assert property (p_xc) else $error("excess not immediate");
  property p_uv;
    !(i_vdd_ok && i_negative_bias_ok) |-> o_disable_status_line_oe && !drv_on;
  endproperty
  a_uv: assert property (p_uv) else $error("lockout not held");
  property p_wl;
    !o_disable_status_line;
  endproperty
  a_wl: assert property (p_wl) else $error("line driven high");
  // The latch shows one edge after the trip, when the comparator may already have dropped
  property p_oc;
    $rose(o_oc_fault) |-> $past(cm) > OC_CYC;
  endproperty
  a_oc: assert property (p_oc) else $error("overcurrent too early");
  property p_ocl;
    cm == OC_CYC + 2 |-> o_oc_fault && o_disable_status_line_oe;
  endproperty
  a_ocl: assert property (p_ocl) else $error("overcurrent too late");
  property p_dt;
    (i_dead_time > 2) && $fell(o_bridge_gate_drive_hi[0]) |=> !o_bridge_gate_drive_lo[0] [*2];
  endproperty
  a_dt: assert property (p_dt) else $error("dead time short");
endmodule
bind dpw_top dpw_top_chk #(.OC_CYC(OC_CYC)) u_chk (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
  .i_dead_time(i_dead_time), .i_oc_low(i_oc_low), .i_oc_high(i_oc_high), .i_vdd_ok(i_vdd_ok),
  .i_negative_bias_ok(i_negative_bias_ok), .i_disable_status_line(i_disable_status_line),
  .o_disable_status_line(o_disable_status_line), .o_oc_fault(o_oc_fault),
  .o_disable_status_line_oe(o_disable_status_line_oe),
  .o_bridge_gate_drive_hi(o_bridge_gate_drive_hi), .o_bridge_gate_drive_lo(o_bridge_gate_drive_lo));

// ==== tb/testbench.sv ====
// Self-checking bench for the dual PWM drive block
`timescale 1ns/1ns
module testbench;
  import dpw_pkg::*;
  localparam int unsigned OCN = 3;
  logic [TW-1:0]   per  = 16'h0028;
  logic [TW-1:0]   dead = 16'h0004;
  logic [TW-1:0]   minp = 16'h000c;
  logic [1:0]      cmp  = 2'h0;
  logic [1:0]      ocl  = 2'h0;
  logic [1:0]      och  = 2'h0;
  logic            clk  = 1'b0;
  logic            srst = 1'b1;
  logic            vok  = 1'b1;
  logic            bok  = 1'b1;
  logic            ext  = 1'b0;
  logic            clr  = 1'b0;
  logic            pq   = 1'b0;
  logic            line, dout, doe, pump, ocf, xcf, uvf, poe;
  logic [1:0]      hi, lo;
  logic [3:0][7:0] rises;
  int              n_fail  = 0;
  int              n_tests = 0;
  int              pumps   = 0;
  // Pull-up on the shared line; either side may pull it low
  assign line = (doe ? dout : 1'b1) & !poe;
  always #20 clk = !clk;
  // Sampled mid-cycle so the registered pump output has settled
  always @(negedge clk)
  begin
    if (pump !== pq)
      pumps = pumps + 1;
    pq = pump;
  end
  dpw_top #(.OC_CYC(OCN)) dut (.i_ref_clk(clk), .i_srst(srst), .i_osc_period(per),
    .i_dead_time(dead), .i_min_pulse(minp), .i_err_cmp(cmp), .i_oc_low(ocl), .i_oc_high(och),
    .i_vdd_ok(vok), .i_negative_bias_ok(bok), .i_disable_status_line(line),
    .o_disable_status_line(dout), .o_disable_status_line_oe(doe), .o_bridge_gate_drive_hi(hi),
    .o_bridge_gate_drive_lo(lo), .o_charge_pump_capacitor(pump), .o_oc_fault(ocf),
    .o_xc_fault(xcf), .o_uv_fault(uvf));
  dpw_bridge_model bm (.i_ref_clk(clk), .i_clr(clr), .i_fault(ext), .i_hi(hi), .i_lo(lo),
    .o_pull_oe(poe), .o_rises(rises));
  ////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    step(2);
    srst = 1'b0;
    // A constant decision must still pulse both legs every period
    for (int v = 0; v < 2; v++)
    begin
      cmp = v ? 2'h3 : 2'h0;
      clr = 1'b1;
      step(1);
      clr = 1'b0;
      pumps = 0;
      step(160);
      chk(rises[0] >= 8'h03 && rises[2] >= 8'h03, "min pulse");
      chk(rises[0] === rises[1] && rises[2] === rises[3], "sync");
      chk(pumps >= 7 && pumps <= 9, "pump rate");
      $display("test duty %0d done", v);
    end
    cmp = 2'h1;
    ext = 1'b1;
    step(1);
    chk({hi, lo} === 4'h0 && doe === 1'b0, "ext disable");
    ext = 1'b0;
    for (int v = 0; v < 2; v++)
    begin
      {vok, bok} = v ? 2'h2 : 2'h1;
      step(1);
      chk(doe === 1'b1 && uvf === 1'b1 && {hi, lo} === 4'h0, "lockout");
      {vok, bok} = 2'h3;
      step(1);
    end
    och = 2'h2;
    #1;
    chk(doe === 1'b1 && xcf === 1'b1 && {hi, lo} === 4'h0, "excess");
    step(1);
    och = 2'h0;
    step(2);
    chk(xcf === 1'b0 && line === 1'b1, "excess gone");
    $display("test gating done");
    // A dip before expiry restarts the qualification count
    ocl = 2'h1;
    step(OCN);
    ocl = 2'h0;
    step(1);
    ocl = 2'h1;
    step(OCN);
    chk(ocf === 1'b0 && doe === 1'b0, "oc early");
    step(2);
    chk(ocf === 1'b1 && doe === 1'b1 && {hi, lo} === 4'h0, "oc trip");
    ocl = 2'h0;
    step(5);
    chk(ocf === 1'b1 && line === 1'b0, "oc held");
    srst = 1'b1;
    step(1);
    srst = 1'b0;
    step(1);
    chk(ocf === 1'b0 && line === 1'b1, "oc cleared");
    $display("test overcurrent done");
    end_of_test;
  end
  initial
  begin
    #100000;
    n_fail++;
    end_of_test;
  end
endmodule
